// ===== hw/prr_rx_port.sv
// Purpose: receive side of a 10/100 MII/RMII port with strap capture
// Assumes: line-side stream and strap pins are asynchronous to hclk
// Notes: registers on AHB-Lite, zero wait states, one level interrupt
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "prr_map.svh"
`default_nettype none

module prr_rx_port (
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  // decoded line-side stream
  input wire logic line_clk,
  input wire logic [4:0] line_data,
  input wire logic line_dv,
  input wire logic line_err,
  input wire logic line_crs,
  input wire logic line_col,
  input wire logic line_lpi,
  input wire logic tx_active,
  input wire logic external_reset_low,
  // shared strap / receive pins
  input wire logic [3:0] rxd_in,
  output logic [3:0] rxd_out,
  output logic [3:0] rxd_oe_n,
  input wire logic rxer_in,
  output logic rxer_out,
  output logic rxer_oe_n,
  input wire logic rxclk_in,
  output logic rxclk_out,
  output logic rxclk_oe_n,
  input wire logic col_in,
  output logic col_out,
  output logic col_oe_n,
  output logic rx_dv,
  output logic crs,
  // captured straps
  output logic reduced_iface_select_strap,
  output logic [2:0] mgmt_addr,
  output logic [2:0] opmode
);

  localparam int SYNC_W = 20;
  localparam logic [7:0] HALF_100 = 8'(`PRR_HALF_100);
  localparam logic [7:0] HALF_10 = 8'(`PRR_HALF_10);
  localparam logic [3:0] SETTLE = 4'(`PRR_STRAP_SETTLE);

  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic lclk_q;
  logic [4:0] l_data;
  logic l_dv, l_err, l_crs, l_col, l_lpi, l_tx, ext_rst_n, l_clk;
  logic [3:0] s_rxd;
  logic s_rxer, s_rxclk, s_col;
  logic line_rise;
  prr_pkg::prr_state_t state;
  logic [3:0] settle_cnt;
  logic [`PRR_CTRL_W-1:0] ctrl;
  logic [`PRR_EV_W-1:0] irq_stat;
  logic [`PRR_EV_W-1:0] irq_mask;
  logic [`PRR_EV_W-1:0] events;
  logic [`PRR_EV_W-1:0] w1c;
  logic wr_pend;
  logic [`PRR_ADDR_MSB:2] wr_addr;
  logic [31:0] rd_word;
  logic [31:0] stat_word;
  logic [7:0] sfd_sh;
  logic [7:0] next_sfd_sh;
  logic sfd_seen;
  logic [7:0] div_cnt;
  logic rx_err_int, lpi_ind;
  logic dv_q, err_q, col_q, lpi_q;
  logic running, echo_block, pass_rmii, frame_dv, mii_err;
  logic speed100, full_duplex, eee_on, symbol_on, soft_rst;

  // two-flop synchronisers for every asynchronous input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {external_reset_low, line_clk, line_data, line_dv, line_err,
                 line_crs, line_col, line_lpi, tx_active, rxd_in, rxer_in,
                 rxclk_in, col_in};
      sync_b <= sync_a;
    end
  end

  assign {ext_rst_n, l_clk, l_data, l_dv, l_err, l_crs, l_col, l_lpi, l_tx,
          s_rxd, s_rxer, s_rxclk, s_col} = sync_b;
  assign speed100 = ctrl[`PRR_CTRL_SPEED100];
  assign full_duplex = ctrl[`PRR_CTRL_FULL_DUPLEX];
  assign eee_on = ctrl[`PRR_CTRL_EEE];
  assign symbol_on = ctrl[`PRR_CTRL_SYMBOL];
  assign soft_rst = ctrl[`PRR_CTRL_SOFT_RESET];
  assign running = (state == prr_pkg::PRR_RUN);

  // line clock edge finder, on synchronised level only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lclk_q <= 1'b0;
    end else begin
      lclk_q <= l_clk;
    end
  end
  assign line_rise = l_clk & ~lclk_q;

  // strap capture: pins are inputs until the straps settle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= prr_pkg::PRR_SAMPLE;
      settle_cnt <= '0;
      reduced_iface_select_strap <= 1'b0;
      mgmt_addr <= 3'h0;
      opmode <= 3'h0;
    end else begin
      case (state)
        prr_pkg::PRR_SAMPLE: begin
          if (!ext_rst_n || soft_rst) begin
            settle_cnt <= '0;
          end else if (settle_cnt == SETTLE - 4'd1) begin
            reduced_iface_select_strap <= s_rxd[2];
            mgmt_addr <= {s_rxd[3], s_rxclk, s_rxer};
            opmode <= {s_col, s_rxd[1], s_rxd[0]};
            state <= prr_pkg::PRR_RUN;
          end else begin
            settle_cnt <= settle_cnt + 4'd1;
          end
        end
        prr_pkg::PRR_RUN: begin
          if (!ext_rst_n || soft_rst) begin
            settle_cnt <= '0;
            state <= prr_pkg::PRR_SAMPLE;
          end
        end
        default: begin
          state <= prr_pkg::PRR_SAMPLE;
        end
      endcase
    end
  end

  // pin direction: drive only once straps are held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_oe_n <= 4'hF;
      rxer_oe_n <= 1'b1;
      rxclk_oe_n <= 1'b1;
      col_oe_n <= 1'b1;
    end else begin
      rxd_oe_n <= {4{~running}};
      rxer_oe_n <= ~running;
      rxclk_oe_n <= ~(running & ~reduced_iface_select_strap);
      col_oe_n <= ~running;
    end
  end

  // mii receive clock divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 8'h00;
      rxclk_out <= 1'b0;
    end else if (!running || reduced_iface_select_strap) begin
      div_cnt <= 8'h00;
      rxclk_out <= 1'b0;
    end else if (div_cnt >= (speed100 ? HALF_100 : HALF_10) - 8'd1) begin
      div_cnt <= 8'h00;
      rxclk_out <= ~rxclk_out;
    end else begin
      div_cnt <= div_cnt + 8'd1;
    end
  end

  // frame qualifiers
  assign echo_block = reduced_iface_select_strap & ~speed100 &
                      ~full_duplex & l_tx;
  assign pass_rmii = speed100 | sfd_seen;
  assign next_sfd_sh = {sfd_sh[5:0], l_data[0], l_data[1]};
  assign frame_dv = reduced_iface_select_strap ?
    (l_dv & l_crs & ~echo_block & pass_rmii) : l_dv;
  assign mii_err = frame_dv ? l_err : (eee_on & l_lpi);

  // delimiter hunt for 10M reduced interface
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sfd_sh <= 8'h00;
      sfd_seen <= 1'b0;
    end else if (!running || !l_crs) begin
      sfd_sh <= 8'h00;
      sfd_seen <= 1'b0;
    end else if (line_rise) begin
      sfd_sh <= next_sfd_sh;
      if (next_sfd_sh == `PRR_SFD) begin
        sfd_seen <= 1'b1;
      end
    end
  end

  // receive outputs, cleared while not running, else updated on line clock edges only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_out <= 4'h0;
      rxer_out <= 1'b0;
      col_out <= 1'b0;
      rx_dv <= 1'b0;
      crs <= 1'b0;
      rx_err_int <= 1'b0;
      lpi_ind <= 1'b0;
    end else if (!running) begin
      rxd_out <= 4'h0;
      rxer_out <= 1'b0;
      col_out <= 1'b0;
      rx_dv <= 1'b0;
      crs <= 1'b0;
      rx_err_int <= 1'b0;
      lpi_ind <= 1'b0;
    end else if (line_rise) begin
      rx_dv <= frame_dv;
      rx_err_int <= frame_dv & l_err;
      lpi_ind <= ~frame_dv & eee_on & l_lpi;
      if (reduced_iface_select_strap) begin
        rxd_out[1:0] <= frame_dv ? l_data[1:0] : 2'b00;
        rxd_out[3:2] <= 2'b00;
        col_out <= l_crs;
        crs <= 1'b0;
        rxer_out <= mii_err;
      end else begin
        rxd_out <= frame_dv ? l_data[3:0] : 4'h0;
        col_out <= l_col;
        crs <= l_crs;
        if (symbol_on) begin
          rxer_out <= frame_dv & l_data[4];
        end else begin
          rxer_out <= mii_err;
        end
      end
    end
  end

  // event edges for the interrupt status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv_q <= 1'b0;
      err_q <= 1'b0;
      col_q <= 1'b0;
      lpi_q <= 1'b0;
    end else begin
      dv_q <= rx_dv;
      err_q <= rx_err_int;
      col_q <= col_out & ~reduced_iface_select_strap;
      lpi_q <= lpi_ind;
    end
  end

  always_comb begin
    events = '0;
    events[`PRR_EV_START] = rx_dv & ~dv_q;
    events[`PRR_EV_END] = ~rx_dv & dv_q;
    events[`PRR_EV_ERR] = rx_err_int & ~err_q;
    events[`PRR_EV_COL] = col_out & ~reduced_iface_select_strap & ~col_q;
    events[`PRR_EV_LPI] = lpi_ind & ~lpi_q;
  end

  // bus address phase capture and read data
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`PRR_STAT_RMII] = reduced_iface_select_strap;
    stat_word[`PRR_STAT_ADDR_LSB +: 3] = mgmt_addr;
    stat_word[`PRR_STAT_MODE_LSB +: 3] = opmode;
    stat_word[`PRR_STAT_READY] = running;
    stat_word[`PRR_STAT_LPI] = lpi_ind;
    case ({haddr[31:`PRR_ADDR_MSB+1] == '0, haddr[`PRR_ADDR_MSB:0]})
      {1'b1, 5'(`PRR_CTRL_OFS)}: rd_word = {27'h000_0000, ctrl};
      {1'b1, 5'(`PRR_STAT_OFS)}: rd_word = stat_word;
      {1'b1, 5'(`PRR_IRQ_STAT_OFS)}: rd_word = {27'h000_0000, irq_stat};
      {1'b1, 5'(`PRR_IRQ_MASK_OFS)}: rd_word = {27'h000_0000, irq_mask};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_pend <= hwrite & (haddr[31:`PRR_ADDR_MSB+1] == '0);
        wr_addr <= haddr[`PRR_ADDR_MSB:2];
        hrdata <= hwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // writes land in the data phase
  assign w1c = (wr_pend && wr_addr == 3'(`PRR_IRQ_STAT_OFS >> 2)) ?
    hwdata[`PRR_EV_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `PRR_CTRL_RESET;
      irq_mask <= '0;
    end else begin
      if (soft_rst && !running) begin
        ctrl[`PRR_CTRL_SOFT_RESET] <= 1'b0; // self-clearing after restart
      end
      if (wr_pend && wr_addr == 3'(`PRR_CTRL_OFS >> 2)) begin
        ctrl <= hwdata[`PRR_CTRL_W-1:0];
      end
      if (wr_pend && wr_addr == 3'(`PRR_IRQ_MASK_OFS >> 2)) begin
        irq_mask <= hwdata[`PRR_EV_W-1:0];
      end
    end
  end

  // sticky status, a new event beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~w1c) | events;
      irq <= |(((irq_stat & ~w1c) | events) & irq_mask);
    end
  end

endmodule : prr_rx_port
`default_nettype wire

// ===== pkg/prr_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 25 MHz system clock, 32-bit AHB-Lite register bus
// Notes: definitions only
`ifndef PRR_MAP_SVH
`define PRR_MAP_SVH

// register byte offsets
`define PRR_CTRL_OFS 32'h0000_0000
`define PRR_STAT_OFS 32'h0000_0004
`define PRR_IRQ_STAT_OFS 32'h0000_0008
`define PRR_IRQ_MASK_OFS 32'h0000_000C
`define PRR_ADDR_MSB 4

// control register fields
`define PRR_CTRL_SPEED100 0
`define PRR_CTRL_FULL_DUPLEX 1
`define PRR_CTRL_EEE 2
`define PRR_CTRL_SYMBOL 3
`define PRR_CTRL_SOFT_RESET 4
`define PRR_CTRL_W 5
`define PRR_CTRL_RESET 5'h03

// status register fields
`define PRR_STAT_RMII 0
`define PRR_STAT_ADDR_LSB 1
`define PRR_STAT_MODE_LSB 4
`define PRR_STAT_READY 7
`define PRR_STAT_LPI 8

// interrupt event bits
`define PRR_EV_START 0
`define PRR_EV_END 1
`define PRR_EV_ERR 2
`define PRR_EV_COL 3
`define PRR_EV_LPI 4
`define PRR_EV_W 5

// start-frame delimiter in arrival order
`define PRR_SFD 8'hAB

// timing
`define PRR_CLK_HZ 25000000
`define PRR_RXCLK_100_HZ 25000000
`define PRR_RXCLK_10_HZ 2500000
`define PRR_HALF_100 ((`PRR_CLK_HZ / (2 * `PRR_RXCLK_100_HZ)) > 0 ? \
  (`PRR_CLK_HZ / (2 * `PRR_RXCLK_100_HZ)) : 1)
`define PRR_HALF_10 ((`PRR_CLK_HZ / (2 * `PRR_RXCLK_10_HZ)) > 0 ? \
  (`PRR_CLK_HZ / (2 * `PRR_RXCLK_10_HZ)) : 1)
`define PRR_STRAP_SETTLE 8

`endif

// ===== pkg/prr_pkg.sv
// Purpose: shared types of the receive port
// Assumes: nothing
// Notes: constants live in prr_map.svh
`default_nettype none
package prr_pkg;
  typedef enum logic [0:0] {
    PRR_SAMPLE,
    PRR_RUN
  } prr_state_t;
endpackage : prr_pkg
`default_nettype wire

// ===== dv/prr_rx_port_sva.sv
// Purpose: port checks of the receive port
// Assumes: bound into prr_rx_port
// Notes: one clock domain
`timescale 1ns/100ps
`default_nettype none
module prr_rx_port_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic external_reset_low,
  input wire logic [3:0] rxd_out,
  input wire logic [3:0] rxd_oe_n,
  input wire logic rxer_oe_n,
  input wire logic rxclk_out,
  input wire logic rxclk_oe_n,
  input wire logic col_out,
  input wire logic col_oe_n,
  input wire logic rx_dv,
  input wire logic crs,
  input wire logic reduced_iface_select_strap,
  input wire logic [2:0] mgmt_addr,
  input wire logic [2:0] opmode
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // pin functions, strap hold and output gating
  AST_HI: assert property (reduced_iface_select_strap |->
    rxd_out[3:2] == 2'b00) else $error("upper lines driven");
  AST_IDLE: assert property (!rx_dv |-> rxd_out == 4'h0)
    else $error("data without valid");
  AST_VALID: assert property (rx_dv |-> rxd_oe_n == 4'h0)
    else $error("valid on released pins");
  AST_HOLD: assert property (!rxd_oe_n[0] && !$past(rxd_oe_n[0])
    |-> $stable({mgmt_addr, opmode})) else $error("straps moved");
  AST_CSDV: assert property (reduced_iface_select_strap && rx_dv
    |-> col_out && !crs) else $error("carrier low in frame");
  AST_CLKSEL: assert property (!col_oe_n |->
    rxclk_oe_n == reduced_iface_select_strap) else $error("clock pin mode");
  AST_RXCLK: assert property (!rxclk_oe_n |-> ##[1:5]
    (rxclk_oe_n || $changed(rxclk_out))) else $error("clock stalled");
  AST_XRST: assert property (!external_reset_low [*4] |=>
    rxd_oe_n == 4'hf && !rx_dv) else $error("reset ignored");
  AST_OE: assert property (rxd_oe_n == {4{col_oe_n}}
    && rxer_oe_n == col_oe_n) else $error("pins split");
endmodule : prr_rx_port_sva
bind prr_rx_port prr_rx_port_sva i_prr_rx_port_sva (
  .hclk, .hresetn, .external_reset_low, .rxd_out, .rxd_oe_n, .rxer_oe_n,
  .rxclk_out, .rxclk_oe_n, .col_out, .col_oe_n, .rx_dv, .crs,
  .reduced_iface_select_strap, .mgmt_addr, .opmode
);
`default_nettype wire

// ===== dv/prr_mac_model.sv
// Purpose: mac side of the receive pins with strap resistors
// Assumes: straps act as pull resistors on released pins
// Notes: keeps the last data unit taken while valid
`timescale 1ns/100ps
`default_nettype none
module prr_mac_model (
  input wire logic hclk,
  input wire logic [6:0] strap,
  input wire logic [3:0] rxd_out,
  input wire logic [3:0] rxd_oe_n,
  input wire logic rxer_out,
  input wire logic rxer_oe_n,
  input wire logic rxclk_out,
  input wire logic rxclk_oe_n,
  input wire logic col_out,
  input wire logic col_oe_n,
  input wire logic rx_dv,
  output logic [3:0] rxd_in,
  output logic rxer_in,
  output logic rxclk_in,
  output logic col_in,
  output logic [3:0] got
);
  // released pins settle to the resistor level
  assign rxd_in = (rxd_oe_n & {strap[5], strap[6], strap[1:0]}) |
    (~rxd_oe_n & rxd_out);
  assign rxer_in = rxer_oe_n ? strap[3] : rxer_out;
  assign rxclk_in = rxclk_oe_n ? strap[4] : rxclk_out;
  assign col_in = col_oe_n ? strap[2] : col_out;
  // take data while valid, error pin left unused
  always_ff @(posedge hclk) begin
    if (rx_dv) begin
      got <= rxd_in;
    end
  end
endmodule : prr_mac_model
`default_nettype wire

// ===== dv/tb_prr_rx_port.sv
// Purpose: self-checking bench of the receive port
// Assumes: bench is bus master and line source
// Notes: strap levels come from the mac model
`timescale 1ns/100ps
`include "prr_map.svh"
`default_nettype none
module tb_prr_rx_port;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, line_clk = 1'b0;
  logic line_dv = 1'b0, line_err = 1'b0, line_crs = 1'b0, line_col = 1'b0;
  logic tx_active = 1'b0, external_reset_low = 1'b1, line_lpi = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
  logic [4:0] line_data = 5'h00;
  logic [6:0] strap = 7'h15;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, irq, rxer_out, rxer_oe_n, rxclk_out, rx_dv;
  wire logic rxclk_oe_n, col_out, col_oe_n, crs, rxer_in, rxclk_in, col_in;
  wire logic reduced_iface_select_strap;
  wire logic [3:0] rxd_out, rxd_oe_n, rxd_in, got;
  wire logic [2:0] mgmt_addr, opmode;
  int num_errors = 0;
  int comparisons = 0;

  prr_rx_port i_prr_rx_port (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .irq, .line_clk, .line_data, .line_dv, .line_err,
    .line_crs, .line_col, .line_lpi, .tx_active, .external_reset_low,
    .rxd_in, .rxd_out, .rxd_oe_n, .rxer_in, .rxer_out, .rxer_oe_n,
    .rxclk_in, .rxclk_out, .rxclk_oe_n, .col_in, .col_out, .col_oe_n,
    .rx_dv, .crs, .reduced_iface_select_strap, .mgmt_addr, .opmode);
  prr_mac_model i_prr_mac_model (.hclk, .strap, .rxd_out, .rxd_oe_n,
    .rxer_out, .rxer_oe_n, .rxclk_out, .rxclk_oe_n, .col_out, .col_oe_n,
    .rx_dv, .rxd_in, .rxer_in, .rxclk_in, .col_in, .got);

  // 25 MHz system clock
  initial begin
    forever #20 hclk = ~hclk;
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // single word transfer, waits on hready in both phases
  task automatic xfer(input logic w, input logic [31:0] a, d);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  // one 320 ns line period; checks what the beat before produced
  // ep packs data lines, carrier, collision, error and valid
  task automatic ls(input logic [4:0] d, input logic [3:0] f,
                    input logic [7:0] ep);
    line_data <= d;
    {line_col, line_err, line_crs, line_dv} <= f;
    line_clk <= 1'b0;
    @(negedge hclk);
    chk("rx", {24'h0, rxd_out, crs, col_out, rxer_out, rx_dv},
      {24'h0, ep});
    repeat (4) @(posedge hclk);
    line_clk <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask : ls

  task automatic t_straps();
    xfer(1'b0, `PRR_STAT_OFS, 32'h0000_0000);
    chk("status", rd, {24'h0, 1'b1, strap[2:0], strap[5:3],
      strap[6]});
    xfer(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    chk("pins", {25'h0, opmode, mgmt_addr, reduced_iface_select_strap},
      {25'h0, strap[2:0], strap[5:3], strap[6]});
  endtask : t_straps

  task automatic t_mii();
    ls(5'h05, 4'b0011, 8'h00);
    ls(5'h0A, 4'b0111, 8'h59);
    ls(5'h03, 4'b1011, 8'hAB);
    ls(5'h00, 4'b0000, 8'h3D);
    ls(5'h00, 4'b0000, 8'h00);
    chk("mac", {28'h0, got}, 32'h0000_0003);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    xfer(1'b0, `PRR_IRQ_STAT_OFS, 32'h0000_0000);
    chk("irq status", rd, 32'h0000_000F);
    xfer(1'b1, `PRR_IRQ_MASK_OFS, 32'h0000_001F);
    repeat (3) @(posedge hclk);
    chk("irq set", {31'h0, irq}, 32'h0000_0001);
    xfer(1'b1, `PRR_IRQ_STAT_OFS, 32'h0000_000F);
    repeat (3) @(posedge hclk);
    chk("irq clear", {31'h0, irq}, 32'h0000_0000);
    xfer(1'b1, `PRR_CTRL_OFS, 32'h0000_000B);
    ls(5'h1C, 4'b0011, 8'h00);
    ls(5'h00, 4'b0000, 8'hCB);
    ls(5'h00, 4'b0000, 8'h00);
  endtask : t_mii

  // receive clock edges counted over 40 cycles, 10M then 100M
  task automatic t_clk();
    int n;
    logic last;
    for (int s = 0; s < 2; s++) begin
      xfer(1'b1, `PRR_CTRL_OFS, s ? 32'h0000_0003 : 32'h0000_0002);
      repeat (10) @(posedge hclk);
      n = 0;
      @(negedge hclk);
      last = rxclk_out;
      repeat (40) begin
        @(negedge hclk);
        if (rxclk_out !== last) n++;
        last = rxclk_out;
      end
      @(posedge hclk);
      chk("rxclk", n,
        s ? 40 / `PRR_HALF_100 : 40 / `PRR_HALF_10);
    end
  endtask : t_clk

  // low-power idle shows on the error pin only outside valid
  task automatic t_eee();
    xfer(1'b1, `PRR_IRQ_STAT_OFS, 32'h0000_001F);
    xfer(1'b1, `PRR_CTRL_OFS, 32'h0000_0007);
    line_lpi <= 1'b1;
    ls(5'h00, 4'b0000, 8'h00);
    xfer(1'b0, `PRR_STAT_OFS, 32'h0000_0000);
    chk("lpi status", rd, {23'h0, 2'b11, strap[2:0], strap[5:3],
      strap[6]});
    ls(5'h05, 4'b0011, 8'h02);
    ls(5'h00, 4'b0000, 8'h59);
    line_lpi <= 1'b0;
    ls(5'h00, 4'b0000, 8'h02);
    ls(5'h00, 4'b0000, 8'h00);
    xfer(1'b0, `PRR_IRQ_STAT_OFS, 32'h0000_0000);
    chk("lpi event", rd, 32'h0000_0013);
  endtask : t_eee

  // new straps picked up by the external reset, then by a soft reset
  task automatic t_reset();
    strap <= 7'h5E;
    external_reset_low <= 1'b0;
    repeat (6) @(posedge hclk);
    external_reset_low <= 1'b1;
    repeat (30) @(posedge hclk);
    t_straps();
    strap <= 7'h6B;
    xfer(1'b1, `PRR_CTRL_OFS, 32'h0000_0013);
    repeat (30) @(posedge hclk);
    t_straps();
    xfer(1'b0, `PRR_CTRL_OFS, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0003);
  endtask : t_reset

  // 10M reduced frame: preamble, delimiter, then one data dibit
  task automatic t_rmii(input logic [31:0] ctrl, input logic tx,
                        input logic [7:0] e);
    xfer(1'b1, `PRR_CTRL_OFS, ctrl);
    tx_active <= tx;
    for (int i = 0; i < 5; i++) begin
      ls({3'b011, i < 4 ? 2'b01 : 2'b11}, 4'b0011,
        i ? 8'h04 : 8'h00);
    end
    ls(5'b01110, 4'b0011, 8'h04);
    ls(5'h00, 4'b0000, e);
    ls(5'h00, 4'b0000, 8'h00);
  endtask : t_rmii

  // reset, then each scenario in turn
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (30) @(posedge hclk);
    t_straps();
    t_mii();
    t_clk();
    t_eee();
    t_reset();
    t_rmii(32'h0000_0002, 1'b0, 8'h25);
    t_rmii(32'h0000_0000, 1'b1, 8'h04);
    conclude();
  end

  // cuts a hang short
  initial begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    conclude();
  end
endmodule : tb_prr_rx_port
`default_nettype wire
